// file: src/adc_pkg.sv
// Shared types and arithmetic for the delay setting control
package adc_pkg;
    `include "adc_regs.svh"

    typedef enum logic [1:0] {
        ADC_RATE_48K     = 2'h0,
        ADC_RATE_44K1    = 2'h1,
        ADC_RATE_32K     = 2'h2,
        ADC_RATE_INVALID = 2'h3
    } adc_rate_t;

    typedef enum logic [2:0] {
        ADC_ERR_OK      = 3'h0,
        ADC_ERR_RANGE   = 3'h1,
        ADC_ERR_NEAR_48 = 3'h2,
        ADC_ERR_NEAR_44 = 3'h3,
        ADC_ERR_NEAR_32 = 3'h4
    } adc_err_t;

    // Nearest step, clamped to the top position
    function automatic logic [3:0] adc_round_step(input logic [15:0] ms, input int unsigned sh);
        logic [16:0] s;
        s = (17'(ms) + (17'h1 << (sh - 1))) >> sh;
        return (s > 17'(`ADC_STEP_MAX)) ? 4'(`ADC_STEP_MAX) : s[3:0];
    endfunction

    function automatic logic [19:0] adc_fixed_us(input logic [3:0] coarse, input logic [3:0] fine);
        return 20'(coarse) * 20'(`ADC_COARSE_STEP_MS * 1000)
             + 20'(fine) * 20'(`ADC_FINE_STEP_MS * 1000);
    endfunction

    function automatic logic adc_in_band(input logic [17:0] cnt, input longint unsigned nom,
                                         input longint unsigned tol);
        return (64'(cnt) + tol >= nom) && (64'(cnt) <= nom + tol);
    endfunction
endpackage

// file: src/adc_rate_meas.sv
// Sample rate measurement and error classification
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs.svh"
module adc_rate_meas import adc_pkg::*; #(
    parameter int unsigned WIN = `ADC_RATE_WIN
) (
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      frame_sync,
    output adc_rate_t      rate_code,
    output adc_err_t       err_code,
    output logic           locked
);
    localparam longint unsigned TOT = 64'(`ADC_CLK_HZ) * 64'(WIN);
    localparam longint unsigned N48 = TOT / `ADC_RATE_48_HZ;
    localparam longint unsigned N44 = TOT / `ADC_RATE_44_HZ;
    localparam longint unsigned N32 = TOT / `ADC_RATE_32_HZ;
    localparam longint unsigned TMO = N32 + (N32 * `ADC_NEAR_PCT) / 100 + 1;

    if (WIN < 1 || TMO >= 64'h40000) begin : g_chk
        $error("adc_rate_meas: window does not fit the counter");
    end

    typedef struct packed {
        logic        fs_m;
        logic        fs_s;
        logic        fs_d;
        logic [17:0] cnt;
        logic [7:0]  edges;
        adc_rate_t   rate;
        adc_err_t    err;
        logic        locked;
    } adc_rm_t;

    adc_rm_t q, n;

    always_comb begin
        n = q;
        n.fs_m = frame_sync;
        n.fs_s = q.fs_m;
        n.fs_d = q.fs_s;
        n.cnt = q.cnt + 18'h1;
        if (q.fs_s && !q.fs_d) begin
            n.edges = q.edges + 8'h1;
        end
        // Silent input must not freeze the last good class
        if (64'(q.cnt) >= TMO) begin
            n.cnt = 18'h0;
            n.edges = 8'h0;
            n.rate = ADC_RATE_INVALID;
            n.err = ADC_ERR_RANGE;
            n.locked = 1'b0;
        end else if (q.fs_s && !q.fs_d && q.edges == 8'(WIN - 1)) begin
            n.cnt = 18'h0;
            n.edges = 8'h0;
            n.locked = 1'b0;
            n.rate = ADC_RATE_INVALID;
            n.err = ADC_ERR_RANGE;
            if (adc_in_band(q.cnt, N48, N48 * `ADC_LOCK_PPM / 1000000)) begin
                n.rate = ADC_RATE_48K;
                n.err = ADC_ERR_OK;
                n.locked = 1'b1;
            end else if (adc_in_band(q.cnt, N44, N44 * `ADC_LOCK_PPM / 1000000)) begin
                n.rate = ADC_RATE_44K1;
                n.err = ADC_ERR_OK;
                n.locked = 1'b1;
            end else if (adc_in_band(q.cnt, N32, N32 * `ADC_LOCK_PPM / 1000000)) begin
                n.rate = ADC_RATE_32K;
                n.err = ADC_ERR_OK;
                n.locked = 1'b1;
            end else if (adc_in_band(q.cnt, N48, N48 * `ADC_NEAR_PCT / 100)) begin
                n.rate = ADC_RATE_48K;
                n.err = ADC_ERR_NEAR_48;
            end else if (adc_in_band(q.cnt, N44, N44 * `ADC_NEAR_PCT / 100)) begin
                n.rate = ADC_RATE_44K1;
                n.err = ADC_ERR_NEAR_44;
            end else if (adc_in_band(q.cnt, N32, N32 * `ADC_NEAR_PCT / 100)) begin
                n.rate = ADC_RATE_32K;
                n.err = ADC_ERR_NEAR_32;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{rate: ADC_RATE_INVALID, err: ADC_ERR_RANGE, default: '0};
        end else begin
            q <= n;
        end
    end

    assign rate_code = q.rate;
    assign err_code = q.err;
    assign locked = q.locked;

    a_rate_err_pair: assert property (@(posedge clk) disable iff (rst)
        (q.rate == ADC_RATE_INVALID) == (q.err == ADC_ERR_RANGE))
        else $error("rate code and error class disagree");
    a_lock_is_ok: assert property (@(posedge clk) disable iff (rst)
        q.locked |-> (q.err == ADC_ERR_OK && q.rate != ADC_RATE_INVALID))
        else $error("locked without a clean rate");
endmodule
`default_nettype wire

// file: src/adc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
`define ADC_CLK_HZ          250000000
`define ADC_FINE_STEP_MS    2
`define ADC_COARSE_STEP_MS  32
`define ADC_FINE_SHIFT      1
`define ADC_COARSE_SHIFT    5
`define ADC_STEP_MAX        15
`define ADC_FIXED_MAX_MS    510
`define ADC_TRACK_MAX       10'h3FF
`define ADC_LOCK_PPM        400
`define ADC_NEAR_PCT        4
`define ADC_RATE_48_HZ      48000
`define ADC_RATE_44_HZ      44100
`define ADC_RATE_32_HZ      32000
`define ADC_RATE_WIN        16
`define ADC_TRACK_US_CODE   29
`define ADC_OFS_PEND_FINE   6'h00
`define ADC_OFS_PEND_COARSE 6'h04
`define ADC_OFS_APPLY       6'h08
`define ADC_OFS_CONFIG      6'h0C
`define ADC_OFS_STATUS      6'h10
`define ADC_OFS_TOTAL       6'h14
`define ADC_OFS_TRACK       6'h18
`define ADC_OFS_RATE        6'h1C
`define ADC_OFS_IRQ_ST      6'h20
`define ADC_OFS_IRQ_MASK    6'h24
`define ADC_APPLY_GO_BIT    0
`define ADC_APPLY_REL_BIT   1
`define ADC_CFG_TRACK_BIT   0
`define ADC_CFG_RESET       1'h1
`define ADC_IRQ_APPLY_BIT   0
`define ADC_IRQ_ALARM_BIT   1
`define ADC_IRQ_RATE_BIT    2
`define ADC_IRQ_TRACK_BIT   3
`define ADC_IRQ_MASK_RESET  4'h0
`define ADC_ST_OVR_BIT      8
`define ADC_ST_REMOK_BIT    9
`define ADC_ST_TRACK_BIT    10
`define ADC_ST_LOCK_BIT     11
`define ADC_ST_ALARM_BIT    12
`define ADC_ST_PEND_LSB     16
`endif

// file: src/adc_top.sv
// Delay setting control: selectors, remote staging, totals, status and alarms
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs.svh"
module adc_top import adc_pkg::*; #(
    parameter int unsigned TRACK_US_PER_CODE = `ADC_TRACK_US_CODE,
    parameter int unsigned RATE_WIN          = `ADC_RATE_WIN
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  coarse_sel,
    input  wire logic [3:0]  fine_sel,
    input  wire logic        remote_lockout_jumper,
    input  wire logic        internal_fault,
    input  wire logic        board_fail,
    input  wire logic        frame_sync,
    input  wire logic [9:0]  tracking_delay_input,
    input  wire logic        tracking_valid,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             irq,
    output logic             alarm,
    output logic             remote_override_flag,
    output logic             tracking_active,
    output logic [19:0]      total_delay_us
);
    // Top code at the largest scale plus 510 ms must still fit twenty bits
    if (TRACK_US_PER_CODE < 1 || TRACK_US_PER_CODE > 524) begin : g_chk
        $error("adc_top: tracking scale overflows the total");
    end

    typedef struct packed {
        logic [7:0]  sel_m;
        logic [7:0]  sel_s;
        logic        jmp_m;
        logic        jmp_s;
        logic [1:0]  flt_m;
        logic [1:0]  flt_s;
        logic [3:0]  pend_fine;
        logic [3:0]  pend_coarse;
        logic [3:0]  rem_fine;
        logic [3:0]  rem_coarse;
        logic        applied;
        logic [3:0]  eff_fine;
        logic [3:0]  eff_coarse;
        logic        track_en;
        logic [9:0]  track_code;
        logic [19:0] track_us;
        logic [19:0] total_us;
        logic        alarm;
        adc_rate_t   prev_rate;
        logic [3:0]  irq_st;
        logic [3:0]  irq_mask;
        logic        irq;
        logic        wait_q;
        logic [31:0] rdata;
    } adc_top_state_t;

    adc_top_state_t q, n;
    adc_rate_t      rate_code;
    adc_err_t       err_code;
    logic           locked;

    adc_rate_meas #(
        .WIN        (RATE_WIN)
    ) u_rate (
        .clk        (clk),
        .rst        (rst),
        .frame_sync (frame_sync),
        .rate_code  (rate_code),
        .err_code   (err_code),
        .locked     (locked)
    );

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    logic        remote_ok;
    logic        start;
    logic        take_wr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [3:0]  ev;
    logic [3:0]  clr;

    always_comb begin
        n = q;
        ev = 4'h0;
        clr = 4'h0;
        rd = 32'h0;
        // Only the second flop feeds logic; the first may be metastable
        n.sel_m = {coarse_sel, fine_sel};
        n.sel_s = q.sel_m;
        n.jmp_m = remote_lockout_jumper;
        n.jmp_s = q.jmp_m;
        n.flt_m = {board_fail, internal_fault};
        n.flt_s = q.flt_m;
        remote_ok = !q.jmp_s;
        // Answer one cycle after the request; the write lands on the accepting edge
        start = (read || write) && q.wait_q;
        take_wr = write && !q.wait_q;
        wd = writedata & be_mask(byteenable);
        n.wait_q = !start;
        unique case (address)
            `ADC_OFS_PEND_FINE:   rd = {28'h0, q.pend_fine};
            `ADC_OFS_PEND_COARSE: rd = {28'h0, q.pend_coarse};
            `ADC_OFS_CONFIG:      rd = {31'h0, q.track_en};
            `ADC_OFS_STATUS: begin
                rd[3:0] = q.eff_fine;
                rd[7:4] = q.eff_coarse;
                rd[`ADC_ST_OVR_BIT] = q.applied;
                rd[`ADC_ST_REMOK_BIT] = remote_ok;
                rd[`ADC_ST_TRACK_BIT] = q.track_en;
                rd[`ADC_ST_LOCK_BIT] = locked;
                rd[`ADC_ST_ALARM_BIT] = q.alarm;
                rd[`ADC_ST_PEND_LSB +: 8] = {q.pend_coarse, q.pend_fine};
            end
            `ADC_OFS_TOTAL:       rd = {12'h0, q.total_us};
            `ADC_OFS_TRACK:       rd = {12'h0, q.track_us};
            `ADC_OFS_RATE:        rd = {27'h0, err_code, rate_code};
            `ADC_OFS_IRQ_ST:      rd = {28'h0, q.irq_st};
            `ADC_OFS_IRQ_MASK:    rd = {28'h0, q.irq_mask};
            default:              rd = 32'h0;
        endcase
        if (start && read) begin
            n.rdata = rd;
        end
        if (take_wr) begin
            unique case (address)
                `ADC_OFS_PEND_FINE: begin
                    if (remote_ok) begin
                        n.pend_fine = adc_round_step(wd[15:0], `ADC_FINE_SHIFT);
                    end
                end
                `ADC_OFS_PEND_COARSE: begin
                    if (remote_ok) begin
                        n.pend_coarse = adc_round_step(wd[15:0], `ADC_COARSE_SHIFT);
                    end
                end
                `ADC_OFS_APPLY: begin
                    if (remote_ok && wd[`ADC_APPLY_GO_BIT]) begin
                        n.rem_fine = q.pend_fine;
                        n.rem_coarse = q.pend_coarse;
                        n.applied = 1'b1;
                        ev[`ADC_IRQ_APPLY_BIT] = 1'b1;
                    end else if (remote_ok && wd[`ADC_APPLY_REL_BIT]) begin
                        n.applied = 1'b0;
                    end
                end
                `ADC_OFS_CONFIG: begin
                    if (byteenable[0]) begin
                        n.track_en = wd[`ADC_CFG_TRACK_BIT];
                    end
                end
                `ADC_OFS_IRQ_ST:   clr = wd[3:0];
                `ADC_OFS_IRQ_MASK: begin
                    if (byteenable[0]) begin
                        n.irq_mask = wd[3:0];
                    end
                end
                default: ;
            endcase
        end
        // Moving the jumper to local-only drops any remote setting
        if (!remote_ok) begin
            n.applied = 1'b0;
        end
        n.eff_fine = n.applied ? n.rem_fine : q.sel_s[3:0];
        n.eff_coarse = n.applied ? n.rem_coarse : q.sel_s[7:4];
        // Tracking code comes from same-clock logic, so no synchroniser
        if (tracking_valid) begin
            n.track_code = tracking_delay_input & `ADC_TRACK_MAX;
            ev[`ADC_IRQ_TRACK_BIT] = 1'b1;
        end
        n.track_us = q.track_en ? 20'(q.track_code) * 20'(TRACK_US_PER_CODE) : 20'h0;
        n.total_us = adc_fixed_us(q.eff_coarse, q.eff_fine) + q.track_us;
        n.alarm = (err_code == ADC_ERR_RANGE) || (|q.flt_s);
        ev[`ADC_IRQ_ALARM_BIT] = n.alarm && !q.alarm;
        // Rate class changes let software follow the rate code without polling
        n.prev_rate = rate_code;
        ev[`ADC_IRQ_RATE_BIT] = rate_code != q.prev_rate;
        // New events beat a same-cycle clear
        n.irq_st = (q.irq_st & ~clr) | ev;
        n.irq = |(n.irq_st & n.irq_mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{track_en: `ADC_CFG_RESET, irq_mask: `ADC_IRQ_MASK_RESET,
                   prev_rate: ADC_RATE_INVALID, wait_q: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    assign readdata = q.rdata;
    assign waitrequest = q.wait_q;
    assign irq = q.irq;
    assign alarm = q.alarm;
    assign remote_override_flag = q.applied;
    assign tracking_active = q.track_en;
    assign total_delay_us = q.total_us;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_total_sum: assert property (
        ##1 q.total_us == $past(adc_fixed_us(q.eff_coarse, q.eff_fine) + q.track_us))
        else $error("total delay is not the sum of its parts");
    a_fixed_ceiling: assert property (
        adc_fixed_us(q.eff_coarse, q.eff_fine) <= 20'(`ADC_FIXED_MAX_MS * 1000))
        else $error("fixed delay above its ceiling");
    a_step_weights: assert property (
        (q.eff_coarse == 4'h1 && q.eff_fine == 4'h1) |-> adc_fixed_us(q.eff_coarse, q.eff_fine)
        == 20'((`ADC_COARSE_STEP_MS + `ADC_FINE_STEP_MS) * 1000))
        else $error("step weights wrong");
    a_lockout_local: assert property (
        q.jmp_s |=> !q.applied && q.eff_fine == $past(q.sel_s[3:0]) && q.eff_coarse ==
        $past(q.sel_s[7:4]))
        else $error("remote setting used while locked out");
    a_apply_takes: assert property (
        (write && !q.wait_q && address == `ADC_OFS_APPLY && writedata[0] && byteenable[0]
         && !q.jmp_s) |=> q.applied && q.eff_fine == $past(q.pend_fine)
        && q.eff_coarse == $past(q.pend_coarse))
        else $error("apply did not take the pending values");
    a_pending_held: assert property (
        (q.applied && !q.jmp_s && !(write && address == `ADC_OFS_APPLY)) |=>
        $stable(q.eff_fine) && $stable(q.eff_coarse))
        else $error("pending value took effect without apply");
    a_fine_round: assert property (
        (write && !q.wait_q && address == `ADC_OFS_PEND_FINE && byteenable == 4'hF && !q.jmp_s
         && writedata == 32'h5) |=> q.pend_fine == 4'h3)
        else $error("fine rounding wrong");
    a_track_amount: assert property (
        ##1 q.track_us == ($past(q.track_en) ? 20'($past(q.track_code)) * 20'(TRACK_US_PER_CODE)
        : 20'h0))
        else $error("tracking amount wrong");
    a_alarm_cause: assert property (
        (q.flt_s != 2'h0) |=> alarm)
        else $error("fault did not raise the alarm");
    // Flag may outlive a jumper move by the one edge it takes to drop
    a_override_flag: assert property (
        remote_override_flag |-> !$past(q.jmp_s) && q.eff_fine == q.rem_fine
        && q.eff_coarse == q.rem_coarse)
        else $error("override flag without remote setting");
    a_bus_answer: assert property (
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle");
    a_irq_level: assert property (
        irq == |(q.irq_st & q.irq_mask))
        else $error("interrupt level wrong");
    // An idle bus must never see an answer cycle
    a_wait_idle: assert property (
        (!read && !write && waitrequest) |=> waitrequest)
        else $error("answer without a request");
    a_lockout_ignores: assert property (
        (write && !q.wait_q && q.jmp_s && (address == `ADC_OFS_PEND_FINE
         || address == `ADC_OFS_PEND_COARSE)) |=> $stable(q.pend_fine) && $stable(q.pend_coarse))
        else $error("remote write landed while locked out");
    // Staged values must round, not truncate
    a_coarse_round: assert property (
        (write && !q.wait_q && address == `ADC_OFS_PEND_COARSE && byteenable == 4'hF
         && !q.jmp_s && writedata == 32'h64) |=> q.pend_coarse == 4'h3)
        else $error("coarse rounding wrong");
    a_step_clamp: assert property (
        (write && !q.wait_q && address == `ADC_OFS_PEND_COARSE && byteenable == 4'hF
         && !q.jmp_s && writedata == 32'h3E8) |=> q.pend_coarse == 4'hF)
        else $error("oversized remote value not clamped");
    a_track_capture: assert property (
        tracking_valid |=> q.track_code == $past(tracking_delay_input))
        else $error("tracking code not captured");
    a_release_drops: assert property (
        (write && !q.wait_q && address == `ADC_OFS_APPLY && byteenable[0] && !writedata[0]
         && writedata[1] && !q.jmp_s) |=> !remote_override_flag)
        else $error("release left the override on");
    a_apply_event: assert property (
        (write && !q.wait_q && address == `ADC_OFS_APPLY && byteenable[0] && writedata[0]
         && !q.jmp_s) |=> q.irq_st[`ADC_IRQ_APPLY_BIT])
        else $error("apply did not flag its event");
    a_alarm_clear: assert property (
        (q.flt_s == 2'h0 && err_code != ADC_ERR_RANGE) |=> !alarm)
        else $error("alarm without a cause");

    c_apply: cover property (q.applied && !$past(q.applied));
    c_lockout_drop: cover property ($past(q.applied) && q.jmp_s);
    c_alarm: cover property (alarm && irq);
    c_locked: cover property (locked && tracking_active && q.track_code != 10'h0);
    c_rate_lock: cover property (locked && !alarm && rate_code == ADC_RATE_48K);
endmodule
`default_nettype wire

// file: verif/adc_far_side.sv
// Far-side model: rotary selectors, lockout jumper, frame sync and tracking source
`timescale 1ns/10ps
`default_nettype none
module adc_far_side (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [15:0] fs_half,
    input  wire logic [3:0] want_coarse,
    input  wire logic [3:0] want_fine,
    input  wire logic       want_local,
    input  wire logic [9:0] trk_code,
    input  wire logic       trk_go,
    output logic [3:0]      coarse_sel,
    output logic [3:0]      fine_sel,
    output logic            remote_lockout_jumper,
    output logic            frame_sync,
    output logic [9:0]      tracking_delay_input,
    output logic            tracking_valid
);
    logic [15:0] fs_cnt_q;
    // Switch and jumper positions follow the bench, as a person would set them
    assign coarse_sel            = want_coarse;
    assign fine_sel              = want_fine;
    assign remote_lockout_jumper = want_local;
    always_ff @(posedge clk) begin
        if (rst) begin
            fs_cnt_q   <= 16'h0000;
            frame_sync <= 1'b0;
        end else if (fs_cnt_q >= fs_half) begin
            // Short half periods stay out of range; the bench picks a lock rate late
            fs_cnt_q   <= 16'h0000;
            frame_sync <= ~frame_sync;
        end else begin
            fs_cnt_q <= fs_cnt_q + 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            tracking_valid       <= 1'b0;
            tracking_delay_input <= 10'h000;
        end else begin
            tracking_valid <= trk_go;
            if (trk_go) begin
                // Ten-bit code, so it never leaves 0 to 3FF
                tracking_delay_input <= trk_code;
            end else begin
                // Line not held between codes: show a changing pattern
                tracking_delay_input <= ~tracking_delay_input;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/adc_top_test.sv
// Self-checking bench for the delay setting control over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module adc_top_test;
    import adc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  w_coarse = 4'h3;
    logic [3:0]  w_fine = 4'h5;
    logic        w_local = 1'b0;
    logic [9:0]  trk_code = 10'h000;
    logic        trk_go = 1'b0;
    logic [15:0] fs_half = 16'd37;
    logic        internal_fault = 1'b0;
    logic        board_fail = 1'b0;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic        waitrequest, irq, alarm, remote_override_flag, tracking_active;
    logic [19:0] total_delay_us;
    logic [3:0]  coarse_sel, fine_sel;
    logic        remote_lockout_jumper, frame_sync, tracking_valid;
    logic [9:0]  tracking_delay_input;
    logic [31:0] q;
    int          err_count = 0;
    int          cmp_count = 0;
    always #2 clk = ~clk;
    adc_far_side FAR (.clk(clk), .rst(rst), .fs_half(fs_half), .want_coarse(w_coarse),
        .want_fine(w_fine),
        .want_local(w_local), .trk_code(trk_code), .trk_go(trk_go),
        .coarse_sel(coarse_sel), .fine_sel(fine_sel),
        .remote_lockout_jumper(remote_lockout_jumper), .frame_sync(frame_sync),
        .tracking_delay_input(tracking_delay_input), .tracking_valid(tracking_valid));
    adc_top #(.RATE_WIN(2)) DUT (.clk(clk), .rst(rst), .coarse_sel(coarse_sel),
        .fine_sel(fine_sel), .remote_lockout_jumper(remote_lockout_jumper),
        .internal_fault(internal_fault), .board_fail(board_fail), .frame_sync(frame_sync),
        .tracking_delay_input(tracking_delay_input), .tracking_valid(tracking_valid),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .alarm(alarm), .remote_override_flag(remote_override_flag),
        .tracking_active(tracking_active), .total_delay_us(total_delay_us));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One Avalon access; the leading edge keeps back-to-back calls from colliding
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        @(posedge clk);
        // Only the watchdog ends a wait that never gets its answer
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask
    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        wt(10);
        rst <= 1'b0;
        wt(8);
        `CHK(total_delay_us, 20'd106000)
        bus(1'b0, `ADC_OFS_CONFIG, 0);
        `CHK(q, 32'h00000001)
        `CHK(tracking_active, 1'b1)
        bus(1'b0, `ADC_OFS_IRQ_MASK, 0);
        `CHK(q, 32'h00000000)
        bus(1'b0, `ADC_OFS_RATE, 0);
        `CHK(q, 32'h00000007)
        `CHK(alarm, 1'b1)
        bus(1'b0, 6'h3C, 0);
        `CHK(q, 32'h00000000)
        w_coarse <= 4'hF;
        w_fine   <= 4'hF;
        wt(8);
        `CHK(total_delay_us, 20'd510000)
        w_coarse <= 4'h3;
        w_fine   <= 4'h5;
        bus(1'b1, `ADC_OFS_PEND_COARSE, 32'd1000);
        bus(1'b0, `ADC_OFS_STATUS, 0);
        `CHK(q[23:20], 4'hF)
        // Staged values must not reach the total before apply
        bus(1'b1, `ADC_OFS_PEND_FINE, 32'd5);
        bus(1'b1, `ADC_OFS_PEND_COARSE, 32'd100);
        bus(1'b0, `ADC_OFS_STATUS, 0);
        `CHK(q[23:16], 8'h33)
        `CHK(total_delay_us, 20'd106000)
        `CHK(remote_override_flag, 1'b0)
        bus(1'b1, `ADC_OFS_IRQ_MASK, 32'h1);
        bus(1'b1, `ADC_OFS_APPLY, 32'h1);
        wt(4);
        `CHK(remote_override_flag, 1'b1)
        `CHK(total_delay_us, 20'd102000)
        `CHK(irq, 1'b1)
        w_coarse <= 4'h9;
        w_fine   <= 4'h9;
        wt(8);
        `CHK(total_delay_us, 20'd102000)
        bus(1'b1, `ADC_OFS_IRQ_ST, 32'h1);
        wt(2);
        `CHK(irq, 1'b0)
        bus(1'b1, `ADC_OFS_APPLY, 32'h2);
        wt(4);
        `CHK(remote_override_flag, 1'b0)
        `CHK(total_delay_us, 20'd306000)
        // Local-only: remote writes and apply have no effect
        w_local <= 1'b1;
        wt(8);
        bus(1'b1, `ADC_OFS_PEND_FINE, 32'd20);
        bus(1'b1, `ADC_OFS_APPLY, 32'h1);
        wt(4);
        `CHK(remote_override_flag, 1'b0)
        bus(1'b0, `ADC_OFS_STATUS, 0);
        `CHK(q[19:16], 4'h3)
        `CHK(total_delay_us, 20'd306000)
        w_local <= 1'b0;
        wt(8);
        bus(1'b1, `ADC_OFS_APPLY, 32'h1);
        wt(4);
        `CHK(remote_override_flag, 1'b1)
        w_local <= 1'b1;
        wt(8);
        `CHK(remote_override_flag, 1'b0)
        trk_code <= 10'h3FF;
        trk_go   <= 1'b1;
        @(posedge clk);
        trk_go <= 1'b0;
        wt(8);
        bus(1'b0, `ADC_OFS_TRACK, 0);
        `CHK(q, 32'd29667)
        `CHK(total_delay_us, 20'd335667)
        bus(1'b1, `ADC_OFS_CONFIG, 32'h0);
        wt(4);
        `CHK(tracking_active, 1'b0)
        bus(1'b0, `ADC_OFS_TRACK, 0);
        `CHK(q, 32'h00000000)
        `CHK(total_delay_us, 20'd306000)
        // A 48 kHz frame rate must lock at the shortened window
        fs_half <= 16'd2603;
        bus(1'b1, `ADC_OFS_CONFIG, 32'h1);
        wt(42000);
        `CHK(tracking_active, 1'b1)
        `CHK(total_delay_us, 20'd335667)
        bus(1'b0, `ADC_OFS_RATE, 0);
        `CHK(q, 32'h00000000)
        bus(1'b0, `ADC_OFS_STATUS, 0);
        `CHK(q[12:8], 5'h0C)
        `CHK(alarm, 1'b0)
        internal_fault <= 1'b1;
        wt(4);
        `CHK(alarm, 1'b1)
        internal_fault <= 1'b0;
        board_fail     <= 1'b1;
        wt(4);
        `CHK(alarm, 1'b1)
        board_fail <= 1'b0;
        wt(4);
        `CHK(alarm, 1'b0)
        close_out();
    end
    // Tests take about 42,000 cycles, mostly the rate lock wait
    initial begin
        wt(60000);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
